// File: hdl/ofd_pkg.sv
// shared constants and types of the output pattern fifo and digital i/o register port
package ofd_pkg;

	// ------------------------------------------------------------
	// bus geometry and responses
	// ------------------------------------------------------------
	localparam int          OFD_ADDR_W  = 12;
	localparam int          OFD_DATA_W  = 32;
	localparam logic [1:0]  OFD_RESP_OK = 2'h0;
	localparam logic [1:0]  OFD_RESP_ERR = 2'h2;

	// ------------------------------------------------------------
	// register indices, byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [7:0]  OFD_IDX_IO_SETTING   = 8'h2A;
	localparam logic [7:0]  OFD_IDX_FIFO_CLEAR   = 8'h2C;
	localparam logic [7:0]  OFD_IDX_FIFO_FLAGS   = 8'h2E;
	localparam logic [7:0]  OFD_IDX_TMR_CNT0     = 8'h30;
	localparam logic [7:0]  OFD_IDX_TMR_CNT1     = 8'h32;
	localparam logic [7:0]  OFD_IDX_TMR_CNT2     = 8'h34;
	localparam logic [7:0]  OFD_IDX_TMR_CTRL     = 8'h36;
	localparam logic [7:0]  OFD_IDX_DIO_DATA     = 8'h3E;
	localparam logic [7:0]  OFD_IDX_PAT_LOW      = 8'h40;
	localparam logic [7:0]  OFD_IDX_PAT_HIGH     = 8'h42;
	localparam logic [7:0]  OFD_IDX_IRQ_STATUS   = 8'h48;
	localparam logic [7:0]  OFD_IDX_IRQ_MASK     = 8'h4A;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int          OFD_IOSET_LSB   = 3;
	localparam int          OFD_IOSET_W     = 4;
	localparam int          OFD_TMR_PORT_LSB = 3;
	localparam int          OFD_IRQ_OVF_BIT  = 0;
	localparam int          OFD_IRQ_EMPTY_BIT = 1;
	localparam int          OFD_IRQ_W       = 2;
	localparam logic [15:0] OFD_DIO_RST     = 16'h0000;
	localparam logic [3:0]  OFD_IOSET_RST   = 4'h0;
	localparam logic [1:0]  OFD_IRQ_RST     = 2'h0;

	// ------------------------------------------------------------
	// drain rates, in MHz against the 25 MHz bus clock
	// ------------------------------------------------------------
	localparam int          OFD_ACC_W    = 6;
	localparam logic [5:0]  OFD_CLK_MHZ  = 6'h19;
	localparam logic [5:0]  OFD_MID_MHZ  = 6'h05;
	localparam logic [5:0]  OFD_FAST_MHZ = 6'h0A;
	localparam int          OFD_FIFO_DEPTH = 256;
	localparam int          OFD_PAT_W    = 32;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		OFD_DRAIN_TIMER,
		OFD_DRAIN_MID,
		OFD_DRAIN_FAST,
		OFD_DRAIN_EXT
	} ofd_drain_t;

	typedef struct packed {
		ofd_drain_t drain_clock_select;
		logic       high_byte_direction;
		logic       low_byte_direction;
	} ofd_io_setting_t;

	typedef struct packed {
		logic full_n;
		logic half_n;
		logic empty_n;
	} ofd_flags_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [1:0] port;
		logic [7:0] data;
	} ofd_tmr_req_t;

	typedef enum logic [3:0] {
		OFD_REG_NONE,
		OFD_REG_IO_SETTING,
		OFD_REG_FIFO_CLEAR,
		OFD_REG_FIFO_FLAGS,
		OFD_REG_TMR,
		OFD_REG_DIO,
		OFD_REG_PAT_LOW,
		OFD_REG_PAT_HIGH,
		OFD_REG_IRQ_STATUS,
		OFD_REG_IRQ_MASK
	} ofd_reg_t;

endpackage : ofd_pkg

// File: hdl/ofd_pattern_mem.sv
// pattern storage of the output fifo, registered read port
`timescale 1ns/1ns
module ofd_pattern_mem #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 256,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic             rd_en,
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data_q
);
	logic [WIDTH-1:0] mem [DEPTH];

	// no reset on the array so it maps onto block ram
	always_ff @(posedge aclk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rd_data_q <= '0;
		else if (rd_en)
			rd_data_q <= mem[rd_addr];
	end
endmodule : ofd_pattern_mem

// File: hdl/ofd_port.sv
// register port: axi4-lite slave, output pattern fifo, timer pass-through, digital i/o
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
// What this block does
// R1: any write to the clear strobe register empties the fifo and stores nothing.
// R2: flags bit 0 reads 0 while the fifo is empty, bits 15 to 3 read 0.
// R3: flags bit 1 reads 0 once occupancy has reached half the depth.
// R4: flags bit 2 reads 0 while the fifo cannot take another entry.
// R5: the four timer offsets forward bits 7:0 to the timer unit and return its byte, upper bits zero.
// R6: a write to the digital i/o register latches as output levels each of its two bytes whose write strobe is set.
// R7: a read of the digital i/o register returns the 16 input levels, not the latch.
// R8: each fifo entry is 32 bits wide.
// R9: the host writes the lower word and then the upper word, and the pair is moved into the fifo.
// R10: a two-bit select picks the drain rate: timer output, 5 MHz, 10 MHz or external clock.
// R11: each byte of the digital port is an output when its direction bit is 0, an input when 1.
// R12: after reset the digital outputs drive 0 until the host writes a new value.
// R13: writing the upper word pushes it together with the latest lower word.
// R14: an upper-word write while the fifo is full is dropped and the fifo is left as it was.
module ofd_port #(
	parameter int DEPTH = ofd_pkg::OFD_FIFO_DEPTH
) (
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic [ofd_pkg::OFD_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]                    s_axi_awprot,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [ofd_pkg::OFD_DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic      [1:0]                    s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [ofd_pkg::OFD_ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]                    s_axi_arprot,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic      [ofd_pkg::OFD_DATA_W-1:0] s_axi_rdata,
	output logic      [1:0]                    s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	output ofd_pkg::ofd_tmr_req_t              tmr_req,
	input  wire logic [7:0]                    tmr_rdata,
	input  wire logic                          tmr_out,
	input  wire logic                          ext_drain_clk,
	input  wire logic [15:0]                   dio_in,
	output logic      [15:0]                   dio_out,
	output logic      [1:0]                    dio_oe,
	output logic      [ofd_pkg::OFD_PAT_W-1:0] pattern_data,
	output logic                               pattern_valid,
	output logic                               irq
);
	import ofd_pkg::*;

	localparam int              AW    = $clog2(DEPTH);
	localparam int              CW    = AW + 1;
	localparam logic [CW-1:0]   FULL  = CW'(DEPTH);
	localparam logic [CW-1:0]   HALF  = CW'(DEPTH / 2);

	// ------------------------------------------------------------
	// address decode, shared by both channels
	// ------------------------------------------------------------
	function automatic ofd_reg_t decode(input logic [OFD_ADDR_W-1:0] a);
		decode = OFD_REG_NONE;
		if (a[1:0] == 2'h0 && a[OFD_ADDR_W-1:10] == '0)
		begin
			case (a[9:2])
				OFD_IDX_IO_SETTING: decode = OFD_REG_IO_SETTING;
				OFD_IDX_FIFO_CLEAR: decode = OFD_REG_FIFO_CLEAR;
				OFD_IDX_FIFO_FLAGS: decode = OFD_REG_FIFO_FLAGS;
				OFD_IDX_TMR_CNT0,
				OFD_IDX_TMR_CNT1,
				OFD_IDX_TMR_CNT2,
				OFD_IDX_TMR_CTRL:   decode = OFD_REG_TMR;
				OFD_IDX_DIO_DATA:   decode = OFD_REG_DIO;
				OFD_IDX_PAT_LOW:    decode = OFD_REG_PAT_LOW;
				OFD_IDX_PAT_HIGH:   decode = OFD_REG_PAT_HIGH;
				OFD_IDX_IRQ_STATUS: decode = OFD_REG_IRQ_STATUS;
				OFD_IDX_IRQ_MASK:   decode = OFD_REG_IRQ_MASK;
				default:            decode = OFD_REG_NONE;
			endcase
		end
	endfunction : decode

	typedef enum logic [1:0] {RD_IDLE, RD_SAMPLE, RD_RESP} rd_state_t;

	ofd_reg_t          wsel;
	ofd_reg_t          rsel;
	ofd_reg_t          rd_sel_q;
	rd_state_t         rd_state_q;
	logic              wr_fire;
	logic              rd_fire;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic [31:0]       rdata_q;
	logic [1:0]        rresp_q;
	ofd_io_setting_t   io_q;
	ofd_flags_t        flags;
	ofd_tmr_req_t      tmr_q;
	logic [15:0]       dio_q;
	logic [15:0]       pat_lo_q;
	logic [CW-1:0]     count_q;
	logic [AW-1:0]     wr_ptr_q;
	logic [AW-1:0]     rd_ptr_q;
	logic              clr;
	logic              hi_wr;
	logic              push;
	logic              pop;
	logic              pat_valid_q;
	logic              tmr_prev_q;
	logic              ext_prev_q;
	logic [OFD_ACC_W-1:0] acc_q;
	logic [OFD_ACC_W-1:0] acc_sum;
	logic              rate_tick;
	logic              drain_tick;
	logic [OFD_IRQ_W-1:0] irq_sts_q;
	logic [OFD_IRQ_W-1:0] irq_mask_q;
	logic [OFD_IRQ_W-1:0] irq_evt;

	// ------------------------------------------------------------
	// bus handshakes
	// ------------------------------------------------------------
	assign wsel          = decode(s_axi_awaddr);
	assign rsel          = decode(s_axi_araddr);
	assign wr_fire       = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
	assign s_axi_awready = wr_fire;
	assign s_axi_wready  = wr_fire;
	// a read is held off while a timer write owns the timer request this cycle
	assign rd_fire       = s_axi_arvalid && rd_state_q == RD_IDLE && !(wr_fire && wsel == OFD_REG_TMR);
	assign s_axi_arready = rd_fire;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rd_state_q == RD_RESP;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_q <= 1'b0;
			bresp_q  <= OFD_RESP_OK;
		end
		else if (wr_fire)
		begin
			bvalid_q <= 1'b1;
			bresp_q  <= (wsel == OFD_REG_NONE) ? OFD_RESP_ERR : OFD_RESP_OK;
		end
		else if (s_axi_bready)
			bvalid_q <= 1'b0;
	end

	// reads take two steps so the timer byte is sampled while its read pulse is out
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rd_state_q <= RD_IDLE;
			rd_sel_q   <= OFD_REG_NONE;
			rdata_q    <= '0;
			rresp_q    <= OFD_RESP_OK;
		end
		else
		begin
			unique case (rd_state_q)
				RD_IDLE:
					if (rd_fire)
					begin
						rd_sel_q   <= rsel;
						rd_state_q <= RD_SAMPLE;
					end
				RD_SAMPLE:
				begin
					rd_state_q <= RD_RESP;
					rresp_q    <= (rd_sel_q == OFD_REG_NONE) ? OFD_RESP_ERR : OFD_RESP_OK;
					rdata_q    <= '0;
					case (rd_sel_q)
						OFD_REG_IO_SETTING: rdata_q[OFD_IOSET_LSB +: OFD_IOSET_W] <= io_q;
						OFD_REG_FIFO_FLAGS: rdata_q[2:0] <= flags;                 // see R2
						OFD_REG_TMR:        rdata_q[7:0] <= tmr_rdata;             // see R5
						OFD_REG_DIO:        rdata_q[15:0] <= dio_in;               // see R7
						OFD_REG_IRQ_STATUS: rdata_q[OFD_IRQ_W-1:0] <= irq_sts_q;
						OFD_REG_IRQ_MASK:   rdata_q[OFD_IRQ_W-1:0] <= irq_mask_q;
						default:            rdata_q <= '0;
					endcase
				end
				RD_RESP:
					if (s_axi_rready)
						rd_state_q <= RD_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// control registers, timer pass-through, digital i/o
	// ------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			io_q <= OFD_IOSET_RST;
		else if (wr_fire && wsel == OFD_REG_IO_SETTING && s_axi_wstrb[0])
			io_q <= s_axi_wdata[OFD_IOSET_LSB +: OFD_IOSET_W];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			tmr_q <= '0;
		else
		begin
			tmr_q.wr <= wr_fire && wsel == OFD_REG_TMR && s_axi_wstrb[0];   // see R5
			tmr_q.rd <= rd_fire && rsel == OFD_REG_TMR;
			if (wr_fire && wsel == OFD_REG_TMR)
			begin
				tmr_q.port <= s_axi_awaddr[OFD_TMR_PORT_LSB +: 2];
				tmr_q.data <= s_axi_wdata[7:0];
			end
			else if (rd_fire && rsel == OFD_REG_TMR)
				tmr_q.port <= s_axi_araddr[OFD_TMR_PORT_LSB +: 2];
		end
	end
	assign tmr_req = tmr_q;

	// outputs stay low from reset so nothing downstream sees a stray level
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			dio_q <= OFD_DIO_RST;                                    // see R12
		else if (wr_fire && wsel == OFD_REG_DIO)
		begin
			if (s_axi_wstrb[0])
				dio_q[7:0] <= s_axi_wdata[7:0];                      // see R6
			if (s_axi_wstrb[1])
				dio_q[15:8] <= s_axi_wdata[15:8];                    // see R6
		end
	end
	assign dio_out = dio_q;
	assign dio_oe  = {!io_q.high_byte_direction, !io_q.low_byte_direction};  // see R11

	// ------------------------------------------------------------
	// pattern fifo
	// ------------------------------------------------------------
	assign clr   = wr_fire && wsel == OFD_REG_FIFO_CLEAR;                 // see R1
	assign hi_wr = wr_fire && wsel == OFD_REG_PAT_HIGH;
	assign push  = hi_wr && count_q != FULL && !clr;                        // see R13, R14
	assign pop   = drain_tick && count_q != '0 && !clr;
	assign flags = '{full_n: count_q != FULL,                                // see R4
	                 half_n: count_q < HALF,                                 // see R3
	                 empty_n: count_q != '0};                                // see R2

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pat_lo_q <= '0;
		else if (wr_fire && wsel == OFD_REG_PAT_LOW)
			pat_lo_q <= s_axi_wdata[15:0];                           // see R9
	end

	// clear wins over a drain in the same cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn || clr)
		begin
			count_q  <= '0;                                          // see R1
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end
		else
		begin
			count_q <= count_q + CW'(push) - CW'(pop);
			if (push)
				wr_ptr_q <= wr_ptr_q + 1'b1;
			if (pop)
				rd_ptr_q <= rd_ptr_q + 1'b1;
		end
	end

	ofd_pattern_mem #(
		.WIDTH (OFD_PAT_W),
		.DEPTH (DEPTH)
	) u_mem (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.wr_en     (push),
		.wr_addr   (wr_ptr_q),
		.wr_data   ({s_axi_wdata[15:0], pat_lo_q}),                  // see R8, R9, R13
		.rd_en     (pop),
		.rd_addr   (rd_ptr_q),
		.rd_data_q (pattern_data)
	);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pat_valid_q <= 1'b0;
		else
			pat_valid_q <= pop;
	end
	assign pattern_valid = pat_valid_q;

	// ------------------------------------------------------------
	// drain rate
	// ------------------------------------------------------------
	// 10 MHz is not a whole divisor of 25 MHz, so a phase accumulator spreads the ticks
	assign acc_sum   = acc_q + ((io_q.drain_clock_select == OFD_DRAIN_MID) ? OFD_MID_MHZ : OFD_FAST_MHZ);
	assign rate_tick = acc_sum >= OFD_CLK_MHZ;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			acc_q      <= '0;
			tmr_prev_q <= 1'b0;
			ext_prev_q <= 1'b0;
		end
		else
		begin
			acc_q      <= rate_tick ? acc_sum - OFD_CLK_MHZ : acc_sum;
			tmr_prev_q <= tmr_out;
			ext_prev_q <= ext_drain_clk;
		end
	end

	// edges slower than half the bus clock only; faster external clocks lose ticks
	always_comb
	begin
		unique case (io_q.drain_clock_select)                            // see R10
			OFD_DRAIN_TIMER: drain_tick = tmr_out && !tmr_prev_q;
			OFD_DRAIN_MID,
			OFD_DRAIN_FAST:  drain_tick = rate_tick;
			OFD_DRAIN_EXT:   drain_tick = ext_drain_clk && !ext_prev_q;
		endcase
	end

	// ------------------------------------------------------------
	// interrupts
	// ------------------------------------------------------------
	assign irq_evt[OFD_IRQ_OVF_BIT]   = hi_wr && !push && !clr;
	assign irq_evt[OFD_IRQ_EMPTY_BIT] = pop && count_q == CW'(1) && !push;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_sts_q  <= OFD_IRQ_RST;
			irq_mask_q <= OFD_IRQ_RST;
		end
		else
		begin
			// a new event beats a write-one-to-clear in the same cycle
			if (wr_fire && wsel == OFD_REG_IRQ_STATUS && s_axi_wstrb[0])
				irq_sts_q <= (irq_sts_q & ~s_axi_wdata[OFD_IRQ_W-1:0]) | irq_evt;
			else
				irq_sts_q <= irq_sts_q | irq_evt;
			if (wr_fire && wsel == OFD_REG_IRQ_MASK && s_axi_wstrb[0])
				irq_mask_q <= s_axi_wdata[OFD_IRQ_W-1:0];
		end
	end
	assign irq = |(irq_sts_q & irq_mask_q);

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_hi_into_room;
		hi_wr && count_q < FULL && !pop;
	endsequence
	sequence s_mid_period;
		!drain_tick [*4] ##1 drain_tick;
	endsequence
	// a new select ends the period check early, the old rate no longer applies
	sequence s_mid_left;
		##[0:4] io_q.drain_clock_select != OFD_DRAIN_MID;
	endsequence

	property p_clear;
		clr |=> count_q == '0 ##0 !flags.empty_n;
	endproperty
	a_clear: assert property (p_clear) else $error("clear did not empty fifo"); // see R1
	property p_empty_flag;
		pop && count_q == CW'(1) && !push |=> !flags.empty_n && pattern_valid ##1 !pattern_valid;
	endproperty
	a_empty_flag: assert property (p_empty_flag) else $error("empty flag wrong"); // see R2
	property p_half;
		s_hi_into_room ##0 count_q == HALF - CW'(1) |=> !flags.half_n;
	endproperty
	a_half: assert property (p_half) else $error("half flag not set"); // see R3
	property p_full;
		s_hi_into_room ##0 count_q == FULL - CW'(1) |=> !flags.full_n;
	endproperty
	a_full: assert property (p_full) else $error("full flag not set"); // see R4
	property p_tmr_write;
		wr_fire && wsel == OFD_REG_TMR && s_axi_wstrb[0]
			|=> tmr_req.wr && tmr_req.data == $past(s_axi_wdata[7:0]) ##1 !tmr_req.wr;
	endproperty
	a_tmr_write: assert property (p_tmr_write) else $error("timer write not forwarded"); // see R5
	property p_dio_latch;
		wr_fire && wsel == OFD_REG_DIO && s_axi_wstrb[1:0] == 2'h3 |=> dio_out == $past(s_axi_wdata[15:0]);
	endproperty
	a_dio_latch: assert property (p_dio_latch) else $error("dio latch wrong"); // see R6
	property p_dio_read;
		rd_fire && rsel == OFD_REG_DIO |=> ##1 s_axi_rvalid && s_axi_rdata[15:0] == $past(dio_in);
	endproperty
	a_dio_read: assert property (p_dio_read) else $error("dio read wrong"); // see R7
	property p_push;
		s_hi_into_room |=> count_q == $past(count_q) + CW'(1);
	endproperty
	a_push: assert property (p_push) else $error("upper word did not push"); // see R9
	property p_rate_mid;
		io_q.drain_clock_select == OFD_DRAIN_MID && drain_tick
			&& $stable(io_q.drain_clock_select) |=> s_mid_period or s_mid_left;
	endproperty
	a_rate_mid: assert property (p_rate_mid) else $error("5 MHz drain period wrong"); // see R10
	property p_dir;
		wr_fire && wsel == OFD_REG_IO_SETTING && s_axi_wstrb[0] && s_axi_wdata[OFD_IOSET_LSB]
			|=> dio_oe[0] == 1'b0;
	endproperty
	a_dir: assert property (p_dir) else $error("input byte still driven"); // see R11
	property p_reset_low;
		!$past(aresetn) |-> dio_out == OFD_DIO_RST;
	endproperty
	a_reset_low: assert property (p_reset_low) else $error("dio not low after reset"); // see R12
	property p_full_drop;
		hi_wr && count_q == FULL && !pop |=> count_q == FULL && $stable(wr_ptr_q);
	endproperty
	a_full_drop: assert property (p_full_drop) else $error("write into full fifo"); // see R14
endmodule : ofd_port

// File: testbench/ofd_tmr_model.sv
// timer unit stand-in answering the byte-wide pass-through requests
`timescale 1ns/1ns
module ofd_tmr_model
	import ofd_pkg::*;
(
	input  wire logic         aclk,
	input  wire ofd_tmr_req_t tmr_req,
	output logic      [7:0]   tmr_rdata
);
	logic [7:0] byte_q [4];
	// ----------------------------------------
	// one byte per port
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (tmr_req.wr)
			byte_q[tmr_req.port] <= tmr_req.data;
	end
	// junk outside a read so a stale byte cannot pass
	assign tmr_rdata = tmr_req.rd ? byte_q[tmr_req.port] : ~byte_q[tmr_req.port];
endmodule : ofd_tmr_model

// File: testbench/ofd_port_tb.sv
// self-checking bench of the register port
`timescale 1ns/1ns
module ofd_port_tb;
	import ofd_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam int DEPTH = 8;
	logic         aclk;
	logic         aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
	logic         rready = 1'h0, tmr_out = 1'h0, ext_clk = 1'h0, gen_on = 1'h0;
	logic [11:0]  awaddr = 12'h000, araddr = 12'h000;
	logic [31:0]  wdata = 32'h0;
	logic [3:0]   wstrb = 4'hF;
	logic [15:0]  dio_in = 16'h0000;
	logic [1:0]   gcnt = 2'h0;
	logic         awready, wready, bvalid, arready, rvalid, pattern_valid, irq;
	logic [1:0]   bresp, rresp, dio_oe;
	logic [31:0]  rdata, pattern_data;
	logic [15:0]  dio_out;
	logic [7:0]   tmr_rdata;
	ofd_tmr_req_t tmr_req;
	logic [31:0]  pq[$];
	int           tq[$];
	int           cyc = 0, mismatches = 0, num_checks = 0;

	ofd_port #(.DEPTH(DEPTH)) i_dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .tmr_req(tmr_req), .tmr_rdata(tmr_rdata), .tmr_out(tmr_out),
		.ext_drain_clk(ext_clk), .dio_in(dio_in), .dio_out(dio_out), .dio_oe(dio_oe),
		.pattern_data(pattern_data), .pattern_valid(pattern_valid), .irq(irq));
	ofd_tmr_model i_tmr (.aclk(aclk), .tmr_req(tmr_req), .tmr_rdata(tmr_rdata));

	initial
	begin
		aclk = 1'h0;
		forever #20 aclk = ~aclk;
	end

	// drain edges run only while enabled, still otherwise
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		gcnt <= gcnt + 2'h1;
		if (gen_on)
		begin
			tmr_out <= gcnt[1];
			ext_clk <= gcnt[1];
		end
		if (pattern_valid === 1'h1)
		begin
			pq.push_back(pattern_data);
			tq.push_back(cyc);
		end
		if (cyc == 20000)
		begin
			mismatches++;
			complete_run();
		end
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(logic [31:0] g, logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic wr(logic [7:0] idx, logic [31:0] d, logic [1:0] er = OFD_RESP_OK);
		@(posedge aclk);
		awaddr <= {2'h0, idx, 2'h0};
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		do @(posedge aclk); while (awready !== 1'h1);
		awvalid <= 1'h0;
		wvalid <= 1'h0;
		bready <= 1'h1;
		do @(posedge aclk); while (bvalid !== 1'h1);
		bready <= 1'h0;
		chk(32'(bresp), 32'(er));
	endtask : wr

	task automatic rd(logic [7:0] idx, logic [31:0] e, logic [1:0] er = OFD_RESP_OK);
		@(posedge aclk);
		araddr <= {2'h0, idx, 2'h0};
		arvalid <= 1'h1;
		do @(posedge aclk); while (arready !== 1'h1);
		arvalid <= 1'h0;
		rready <= 1'h1;
		do @(posedge aclk); while (rvalid !== 1'h1);
		rready <= 1'h0;
		chk(rdata, e);
		chk(32'(rresp), 32'(er));
	endtask : rd

	task automatic wait_n(int n);
		int k;
		k = 0;
		while (pq.size() < n && k < 200)
		begin
			@(posedge aclk);
			k++;
		end
		repeat (8) @(posedge aclk);
		chk(32'(pq.size()), 32'(n));
	endtask : wait_n

	task automatic done(string n);
		$display("test %s ended, checks %0d mismatches %0d", n, num_checks, mismatches);
	endtask : done

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		int g;
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		chk(32'(dio_out), 32'h0);
		rd(OFD_IDX_FIFO_FLAGS, 32'h6);
		done("reset");
		dio_in <= 16'h3C96;
		wr(OFD_IDX_DIO_DATA, 32'h0000_A55A);
		chk(32'(dio_out), 32'hA55A);
		rd(OFD_IDX_DIO_DATA, 32'h3C96);
		for (int d = 0; d < 4; d++)
		begin
			wr(OFD_IDX_IO_SETTING, 32'(d << 3));
			chk(32'(dio_oe), 32'(~d & 3));
			rd(OFD_IDX_IO_SETTING, 32'(d << 3));
		end
		done("dio");
		for (int p = 0; p < 4; p++)
			wr(OFD_IDX_TMR_CNT0 + 8'(2 * p), 32'hFFFF_FF30 + 32'(p));
		for (int p = 0; p < 4; p++)
			rd(OFD_IDX_TMR_CNT0 + 8'(2 * p), 32'h30 + 32'(p));
		wr(8'h01, 32'h0, OFD_RESP_ERR);
		rd(8'h01, 32'h0, OFD_RESP_ERR);
		done("timer");
		// one push past full, must be dropped
		for (int i = 0; i < DEPTH + 1; i++)
		begin
			wr(OFD_IDX_PAT_LOW, 32'hA000 + 32'(i));
			wr(OFD_IDX_PAT_HIGH, 32'h5000 + 32'(i));
			if (i == DEPTH / 2 - 1)
				rd(OFD_IDX_FIFO_FLAGS, 32'h5);
		end
		rd(OFD_IDX_FIFO_FLAGS, 32'h1);
		rd(OFD_IDX_IRQ_STATUS, 32'h1);
		chk(32'(irq), 32'h0);
		wr(OFD_IDX_IRQ_MASK, 32'h3);
		chk(32'(irq), 32'h1);
		gen_on <= 1'h1;
		wait_n(DEPTH);
		for (int i = 0; i < DEPTH; i++)
			chk(pq[i], {16'h5000 + 16'(i), 16'hA000 + 16'(i)});
		gen_on <= 1'h0;
		rd(OFD_IDX_FIFO_FLAGS, 32'h6);
		rd(OFD_IDX_IRQ_STATUS, 32'h3);
		wr(OFD_IDX_IRQ_STATUS, 32'h3);
		chk(32'(irq), 32'h0);
		done("full");
		wr(OFD_IDX_PAT_LOW, 32'h1111);
		wr(OFD_IDX_PAT_HIGH, 32'h2222);
		rd(OFD_IDX_FIFO_FLAGS, 32'h7);
		wr(OFD_IDX_FIFO_CLEAR, 32'hFFFF_FFFF);
		rd(OFD_IDX_FIFO_FLAGS, 32'h6);
		done("clear");
		// low word written once, reused by three high writes
		for (int s = 0; s < 4; s++)
		begin
			wr(OFD_IDX_IO_SETTING, 32'h0);
			wr(OFD_IDX_PAT_LOW, 32'hC0DE);
			for (int j = 0; j < 3; j++)
				wr(OFD_IDX_PAT_HIGH, 32'(16 * s + j));
			pq.delete();
			tq.delete();
			wr(OFD_IDX_IO_SETTING, 32'(s << 5));
			gen_on <= 1'h1;
			wait_n(3);
			for (int j = 0; j < 3; j++)
				chk(pq[j], {16'(16 * s + j), 16'hC0DE});
			g = tq[2] - tq[1];
			chk(32'(s == 2 ? (g == 2 || g == 3) : g == (s == 1 ? 5 : 4)), 32'h1);
			gen_on <= 1'h0;
		end
		done("rates");
		complete_run();
	end
endmodule : ofd_port_tb
